/* File: src/mpcw_pkg.sv */
// Purpose: constants for the mode and pin configuration register with watchdog control
// Assumes: one device clock at 250 MHz; register word at the configuration offset
// Notes:   counts are in milliseconds unless the name says edges
//
// Summary of operation
// - the watchdog period field picks 60 ms, 600 ms, 3 s or 6 s for codes 00 to 11 and resets to 00.
// - the reference select bit says the external clock runs at 20 MHz for 0 or 40 MHz for 1 and resets to 1.
// - the second output pin shows nothing, controller interrupt 0 low, the watchdog output or the interrupt pin.
// - the test enable bit puts the device in test mode while 1 and resets to 0.
// - the wake pin rail bit powers the pin buffer from the internal rail for 0 or the I/O rail for 1.
// - the host writes 1 to the restart bit to restart the watchdog, and the bit clears itself.
// - on watchdog expiry the restart bit is set and the selected timeout action is carried out.
// - the timeout action sets the flag and pulls watchdog pins low, pulses the inhibit pin, or pulses the output.
// - every watchdog timeout sets the watchdog interrupt flag whatever the action.
// - the first I/O pin is a general output for 00 and the watchdog trigger input for 10.
// - the fail-safe bit enables fail-safe mode while 1, leaving power-up behaviour alone, and resets to 0.
// - as an output the first I/O pin drives the serial fault, controller interrupt 1 or supply event, active low.
// - the inhibit disable bit leaves the inhibit pin working for 0 and disables it for 1.
// - the wake pin mirrors the inhibit function for 0 and is a wake request interrupt for 1.
// - the watchdog enable bit stops the watchdog for 0, runs it for 1, and resets to 1.
// - the mode field encodes sleep 00, standby 01, normal 10 and reads back the mode actually in force.
`default_nettype none
package mpcw_pkg;
    // ****************************************************************
    // register placement and fields
    // ****************************************************************
    localparam logic [15:0] MPCW_CFG_OFFSET = 16'h0800;
    localparam int          POS_PERIOD      = 28;
    localparam int          POS_REF         = 27;
    localparam int          POS_OUT2        = 22;
    localparam int          POS_TEST        = 21;
    localparam int          POS_RAIL        = 19;
    localparam int          POS_RESTART     = 18;
    localparam int          POS_ACTION      = 16;
    localparam int          POS_IO1_FN      = 14;
    localparam int          POS_FAILSAFE    = 13;
    localparam int          POS_IO1_SRC     = 10;
    localparam int          POS_SUPPLY_CTL_PIN_DISABLE     = 9;
    localparam int          POS_WAKE_FN     = 8;
    localparam int          POS_MODE        = 6;
    localparam int          POS_ONE_BIT     = 5;
    localparam int          POS_WATCHDOG_ENABLE       = 3;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [1:0]  RST_PERIOD      = 2'h0;
    localparam logic        RST_REF         = 1'h1;
    localparam logic [1:0]  RST_OUT2        = 2'h0;
    localparam logic        RST_TEST        = 1'h0;
    localparam logic        RST_RAIL        = 1'h0;
    localparam logic [1:0]  RST_ACTION      = 2'h0;
    localparam logic [1:0]  RST_IO1_FN      = 2'h0;
    localparam logic        RST_FAILSAFE    = 1'h0;
    localparam logic [1:0]  RST_IO1_SRC     = 2'h1;
    localparam logic        RST_SUPPLY_CTL_PIN_DISABLE     = 1'h0;
    localparam logic        RST_WAKE_FN     = 1'h0;
    localparam logic        RST_WATCHDOG_ENABLE       = 1'h1;
    // ****************************************************************
    // encodings
    // ****************************************************************
    localparam logic [1:0]  MODE_SLEEP      = 2'h0;
    localparam logic [1:0]  MODE_STANDBY    = 2'h1;
    localparam logic [1:0]  MODE_NORMAL     = 2'h2;
    localparam logic [1:0]  MODE_RSVD       = 2'h3;
    localparam logic [1:0]  RST_MODE        = MODE_STANDBY;
    localparam logic [1:0]  ACT_FLAG        = 2'h0;
    localparam logic [1:0]  ACT_INH_PULSE   = 2'h1;
    localparam logic [1:0]  ACT_WDO_PULSE   = 2'h2;
    localparam logic [1:0]  OUT2_NONE       = 2'h0;
    localparam logic [1:0]  OUT2_CTRL_IRQ0  = 2'h1;
    localparam logic [1:0]  OUT2_WDO        = 2'h2;
    localparam logic [1:0]  OUT2_IRQ_PIN    = 2'h3;
    localparam logic [1:0]  IO1_OUTPUT      = 2'h0;
    localparam logic [1:0]  IO1_WD_INPUT    = 2'h2;
    localparam logic [1:0]  SRC_SPI_FAULT   = 2'h0;
    localparam logic [1:0]  SRC_CTRL_IRQ1   = 2'h1;
    localparam logic [1:0]  SRC_SUPPLY_EVT  = 2'h2;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int          CLK_MHZ         = 250;
    localparam int          REF_LO_MHZ      = 20;
    localparam int          REF_HI_MHZ      = 40;
    localparam int          REF_LO_EDGES_MS = REF_LO_MHZ * 1000;
    localparam int          REF_HI_EDGES_MS = REF_HI_MHZ * 1000;
    localparam logic [12:0] WD_P0_MS        = 13'd60;
    localparam logic [12:0] WD_P1_MS        = 13'd600;
    localparam logic [12:0] WD_P2_MS        = 13'd3000;
    localparam logic [12:0] WD_P3_MS        = 13'd6000;
    localparam logic [12:0] PULSE_MS        = 13'd300;
endpackage
`default_nettype wire

/* File: src/mpcw_ms_tick.sv */
// Purpose: millisecond enable pulse counted from the external reference clock pin
// Assumes: reference pin toggles well below half the device clock rate
// Notes:   edge counts are parameters so a simulation can shorten them
`default_nettype none
module mpcw_ms_tick
    import mpcw_pkg::*;
#(
    parameter int EDGES_LO = REF_LO_EDGES_MS,
    parameter int EDGES_HI = REF_HI_EDGES_MS
) (
    input  wire logic sys_clk_i,   // device clock
    input  wire logic sys_rst_i,   // synchronous reset, high
    input  wire logic ref_pin_i,   // external reference clock pin
    input  wire logic ref_sel_i,   // 1: fast reference
    output logic      ms_tick_o    // one cycle per millisecond
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic [15:0] cnt;
        logic        tick;
    } mpcw_tick_t;

    mpcw_tick_t st_ff;
    mpcw_tick_t nxt_st;
    logic [15:0] last;

    always_comb begin
        nxt_st      = st_ff;
        last        = ref_sel_i ? 16'(EDGES_HI - 1) : 16'(EDGES_LO - 1);
        nxt_st.s1   = ref_pin_i;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;
        nxt_st.tick = 1'b0;
        if (st_ff.s2 && !st_ff.s3) begin
            if (st_ff.cnt >= last) begin
                nxt_st.cnt  = 16'h0000;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ms_tick_o = st_ff.tick;
endmodule
`default_nettype wire

/* File: src/mpcw_cfg.sv */
// Purpose: mode and pin configuration register with watchdog and pin function logic
// Assumes: register strobes come from the serial front end on the same clock
// Notes:   bits 31:30 and other fields outside this block read as zero
`default_nettype none
module mpcw_cfg
    import mpcw_pkg::*;
#(
    parameter int EDGES_LO = REF_LO_EDGES_MS,
    parameter int EDGES_HI = REF_HI_EDGES_MS
) (
    input  wire logic        sys_clk_i,        // device clock
    input  wire logic        sys_rst_i,        // synchronous reset, high
    input  wire logic        cfg_wr_i,         // write strobe for the register word
    input  wire logic [31:0] cfg_wdata_i,      // write data
    output logic      [31:0] cfg_rdata_o,      // read data
    input  wire logic        ext_clock_in_i,   // reference clock pin
    input  wire logic [1:0]  ctrl_irq_line_i,  // controller interrupt lines, high active
    input  wire logic        irq_out_low_i,    // level of the low active interrupt pin
    input  wire logic        spi_fault_irq_i,  // unmasked serial fault, high active
    input  wire logic        supply_evt_irq_i, // undervoltage or thermal event, high active
    input  wire logic        wake_irq_i,       // wake request event, high active
    input  wire logic        wd_irq_clr_i,     // clears the watchdog interrupt flag
    input  wire logic        io1_pin_i,        // first I/O pin input
    output logic             io1_pin_o,        // first I/O pin output
    output logic             io1_pin_oe_n_o,   // first I/O pin enable, low drives
    output logic             out2_pin_o,       // second output pin
    output logic             supply_ctl_pin_o, // inhibit pin, high keeps supply on
    output logic             wake_req_pin_o,   // wake request pin output
    output logic             wake_req_oe_n_o,  // wake request pin enable, low drives
    output logic             wake_req_rail_o,  // 1: buffer on I/O supply rail
    output logic             wd_irq_flag_o,    // watchdog interrupt flag
    output logic             test_mode_o,      // device in test mode
    output logic             fail_safe_en_o,   // fail-safe mode enabled
    output logic             ref_sel_o,        // 1: 40 MHz reference
    output logic [1:0]       mode_o            // operating mode in force
);
    typedef struct packed {
        logic [1:0]  period;
        logic        ref_sel;
        logic [1:0]  out2_fn;
        logic        test_en;
        logic        rail;
        logic        restart;
        logic [1:0]  action;
        logic [1:0]  io1_fn;
        logic        fail_safe;
        logic [1:0]  io1_src;
        logic        supply_ctl_pin_disable;
        logic        wake_fn;
        logic [1:0]  mode;
        logic        watchdog_enable;
        logic [12:0] wd_cnt;
        logic [12:0] pulse_cnt;
        logic        pulse_inh;
        logic        pulse_wdo;
        logic        wdo_hold;
        logic        irq_flag;
        logic        io1_s1;
        logic        io1_s2;
        logic        io1_s3;
        logic        io1_out;
        logic        out2_out;
        logic        inh_out;
        logic        wake_out;
    } mpcw_state_t;

    mpcw_state_t st_ff;
    mpcw_state_t nxt_st;
    logic        ms_tick;
    logic        expire;
    logic        restart_req;
    logic        wdo_level;

    // ****************************************************************
    // reference tick
    // ****************************************************************
    mpcw_ms_tick #(
        .EDGES_LO (EDGES_LO),
        .EDGES_HI (EDGES_HI)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ref_pin_i (ext_clock_in_i),
        .ref_sel_i (st_ff.ref_sel),
        .ms_tick_o (ms_tick)
    );

    function automatic logic [12:0] period_ms(input logic [1:0] sel);
        logic [12:0] r;
        unique case (sel)
            2'h0: r = WD_P0_MS;
            2'h1: r = WD_P1_MS;
            2'h2: r = WD_P2_MS;
            2'h3: r = WD_P3_MS;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st      = st_ff;
        expire      = st_ff.watchdog_enable && ms_tick && (st_ff.wd_cnt >= period_ms(st_ff.period) - 13'd1);
        restart_req = (cfg_wr_i && cfg_wdata_i[POS_RESTART])
                    || (st_ff.io1_fn == IO1_WD_INPUT && st_ff.io1_s2 && !st_ff.io1_s3);
        wdo_level   = !(st_ff.wdo_hold || st_ff.pulse_wdo);
        nxt_st.io1_s1 = io1_pin_i;
        nxt_st.io1_s2 = st_ff.io1_s1;
        nxt_st.io1_s3 = st_ff.io1_s2;
        if (cfg_wr_i) begin
            nxt_st.period    = cfg_wdata_i[POS_PERIOD +: 2];
            nxt_st.ref_sel   = cfg_wdata_i[POS_REF];
            nxt_st.out2_fn   = cfg_wdata_i[POS_OUT2 +: 2];
            nxt_st.test_en   = cfg_wdata_i[POS_TEST];
            nxt_st.rail      = cfg_wdata_i[POS_RAIL];
            nxt_st.action    = cfg_wdata_i[POS_ACTION +: 2];
            nxt_st.io1_fn    = cfg_wdata_i[POS_IO1_FN +: 2];
            nxt_st.fail_safe = cfg_wdata_i[POS_FAILSAFE];
            nxt_st.io1_src   = cfg_wdata_i[POS_IO1_SRC +: 2];
            nxt_st.supply_ctl_pin_disable   = cfg_wdata_i[POS_SUPPLY_CTL_PIN_DISABLE];
            nxt_st.wake_fn   = cfg_wdata_i[POS_WAKE_FN];
            nxt_st.watchdog_enable     = cfg_wdata_i[POS_WATCHDOG_ENABLE];
            if (cfg_wdata_i[POS_MODE +: 2] != MODE_RSVD) begin
                nxt_st.mode = cfg_wdata_i[POS_MODE +: 2];
            end
        end
        // watchdog count, restart and expiry
        if (!st_ff.watchdog_enable || restart_req || expire) begin
            nxt_st.wd_cnt = 13'h0000;
        end else if (ms_tick) begin
            nxt_st.wd_cnt = st_ff.wd_cnt + 13'd1;
        end
        if (restart_req) begin
            nxt_st.restart  = 1'b0;
            nxt_st.wdo_hold = 1'b0;
        end
        if (wd_irq_clr_i) begin
            nxt_st.irq_flag = 1'b0;
        end
        if (expire) begin
            nxt_st.restart  = 1'b1;
            nxt_st.irq_flag = 1'b1;
            unique case (st_ff.action)
                ACT_FLAG:      nxt_st.wdo_hold = 1'b1;
                ACT_INH_PULSE: begin
                    nxt_st.pulse_inh = 1'b1;
                    nxt_st.pulse_cnt = 13'h0000;
                    nxt_st.mode      = MODE_STANDBY;
                end
                ACT_WDO_PULSE: begin
                    nxt_st.pulse_wdo = 1'b1;
                    nxt_st.pulse_cnt = 13'h0000;
                end
                default:       nxt_st.wdo_hold = st_ff.wdo_hold;
            endcase
        end else if ((st_ff.pulse_inh || st_ff.pulse_wdo) && ms_tick) begin
            if (st_ff.pulse_cnt >= PULSE_MS - 13'd1) begin
                nxt_st.pulse_inh = 1'b0;
                nxt_st.pulse_wdo = 1'b0;
            end else begin
                nxt_st.pulse_cnt = st_ff.pulse_cnt + 13'd1;
            end
        end
        // pin drivers, all registered
        unique case (st_ff.io1_src)
            SRC_SPI_FAULT:  nxt_st.io1_out = !spi_fault_irq_i;
            SRC_CTRL_IRQ1:  nxt_st.io1_out = !ctrl_irq_line_i[1];
            SRC_SUPPLY_EVT: nxt_st.io1_out = !supply_evt_irq_i;
            default:        nxt_st.io1_out = 1'b1;
        endcase
        unique case (st_ff.out2_fn)
            OUT2_NONE:      nxt_st.out2_out = 1'b1;
            OUT2_CTRL_IRQ0: nxt_st.out2_out = !ctrl_irq_line_i[0];
            OUT2_WDO:       nxt_st.out2_out = wdo_level;
            OUT2_IRQ_PIN:   nxt_st.out2_out = irq_out_low_i;
        endcase
        nxt_st.inh_out  = !st_ff.supply_ctl_pin_disable && !st_ff.pulse_inh && st_ff.mode != MODE_SLEEP;
        nxt_st.wake_out = st_ff.wake_fn ? !wake_irq_i : !st_ff.inh_out;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_ff           <= '0;
            st_ff.period    <= RST_PERIOD;
            st_ff.ref_sel   <= RST_REF;
            st_ff.out2_fn   <= RST_OUT2;
            st_ff.test_en   <= RST_TEST;
            st_ff.rail      <= RST_RAIL;
            st_ff.action    <= RST_ACTION;
            st_ff.io1_fn    <= RST_IO1_FN;
            st_ff.fail_safe <= RST_FAILSAFE;
            st_ff.io1_src   <= RST_IO1_SRC;
            st_ff.supply_ctl_pin_disable   <= RST_SUPPLY_CTL_PIN_DISABLE;
            st_ff.wake_fn   <= RST_WAKE_FN;
            st_ff.mode      <= RST_MODE;
            st_ff.watchdog_enable     <= RST_WATCHDOG_ENABLE;
            st_ff.io1_out   <= 1'b1;
            st_ff.out2_out  <= 1'b1;
            st_ff.inh_out   <= 1'b1;
            st_ff.wake_out  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb begin
        cfg_rdata_o                       = 32'h0000_0000;
        cfg_rdata_o[POS_PERIOD +: 2]      = st_ff.period;
        cfg_rdata_o[POS_REF]              = st_ff.ref_sel;
        cfg_rdata_o[POS_OUT2 +: 2]        = st_ff.out2_fn;
        cfg_rdata_o[POS_TEST]             = st_ff.test_en;
        cfg_rdata_o[POS_RAIL]             = st_ff.rail;
        cfg_rdata_o[POS_RESTART]          = st_ff.restart;
        cfg_rdata_o[POS_ACTION +: 2]      = st_ff.action;
        cfg_rdata_o[POS_IO1_FN +: 2]      = st_ff.io1_fn;
        cfg_rdata_o[POS_FAILSAFE]         = st_ff.fail_safe;
        cfg_rdata_o[POS_IO1_SRC +: 2]     = st_ff.io1_src;
        cfg_rdata_o[POS_SUPPLY_CTL_PIN_DISABLE]          = st_ff.supply_ctl_pin_disable;
        cfg_rdata_o[POS_WAKE_FN]          = st_ff.wake_fn;
        cfg_rdata_o[POS_MODE +: 2]        = st_ff.mode;
        cfg_rdata_o[POS_ONE_BIT]          = 1'b1;
        cfg_rdata_o[POS_WATCHDOG_ENABLE]            = st_ff.watchdog_enable;
    end

    assign io1_pin_o        = st_ff.io1_out;
    assign io1_pin_oe_n_o   = st_ff.io1_fn != IO1_OUTPUT;
    assign out2_pin_o       = st_ff.out2_out;
    assign supply_ctl_pin_o = st_ff.inh_out;
    assign wake_req_pin_o   = st_ff.wake_out;
    assign wake_req_oe_n_o  = st_ff.rail && st_ff.wake_out;
    assign wake_req_rail_o  = st_ff.rail;
    assign wd_irq_flag_o    = st_ff.irq_flag;
    assign test_mode_o      = st_ff.test_en;
    assign fail_safe_en_o   = st_ff.fail_safe;
    assign ref_sel_o        = st_ff.ref_sel;
    assign mode_o           = st_ff.mode;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_expire_flag;
        expire ##1 st_ff.restart;
    endsequence

    reset_values_a: assert property (disable iff (1'b0) sys_rst_i |=> st_ff.period == 2'h0 && ref_sel_o
        && !test_mode_o && st_ff.watchdog_enable && st_ff.io1_src == 2'h1) else $error("reset values wrong");
    period_load_a: assert property (cfg_wr_i |=> st_ff.period == $past(cfg_wdata_i[29:28]))
        else $error("period field not loaded");
    restart_self_a: assert property (cfg_wr_i && cfg_wdata_i[18] && !expire |=> !st_ff.restart
        && st_ff.wd_cnt == 13'h0000) else $error("restart did not clear");
    expire_flag_a: assert property (expire |-> s_expire_flag) else $error("timeout did not set restart bit");
    timeout_irq_a: assert property (expire |=> wd_irq_flag_o) else $error("timeout flag missing");
    inh_pulse_a: assert property (expire && st_ff.action == 2'h1 && !st_ff.supply_ctl_pin_disable |=> mode_o == 2'h1
        ##1 !supply_ctl_pin_o) else $error("inhibit pulse missing");
    io1_source_a: assert property (st_ff.io1_src == 2'h0 |=> io1_pin_o == !$past(spi_fault_irq_i))
        else $error("io1 source wrong");
    out2_mirror_a: assert property (st_ff.out2_fn == 2'h3 && !cfg_wr_i |=> out2_pin_o == $past(irq_out_low_i))
        else $error("out2 mirror wrong");
    wd_off_a: assert property (!st_ff.watchdog_enable |=> st_ff.wd_cnt == 13'h0000 && !expire) else $error("watchdog runs");
    mode_readback_a: assert property (cfg_rdata_o[7:6] == mode_o && mode_o != 2'h3)
        else $error("mode readback wrong");
endmodule
`default_nettype wire

/* File: test/mpcw_host.sv */
// Purpose: host model that issues whole register word writes
// Assumes: strobe launched after a falling edge, held across one rising edge
// Notes:   released data shows the inverse so stale values are not mistaken for live ones
`default_nettype none
module mpcw_host (
    input  wire logic        sys_clk_i,   // device clock
    output logic             cfg_wr_o,    // write strobe
    output logic      [31:0] cfg_wdata_o  // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_wr_o    = 1'b0;
        cfg_wdata_o = 32'h0000_0000;
    end
    // bit 18 set in w services the watchdog
    task automatic write(input logic [31:0] w);
        @(negedge sys_clk_i);
        cfg_wr_o    <= 1'b1;
        cfg_wdata_o <= w;
        @(negedge sys_clk_i);
        cfg_wr_o    <= 1'b0;
        cfg_wdata_o <= ~w;
    endtask
endmodule
`default_nettype wire

/* File: test/tb_mpcw_cfg.sv */
// Purpose: self-checking bench for the mode and pin configuration register
// Assumes: reference edge counts shortened to 4 and 8 per millisecond
// Notes:   reference rises every 8 cycles, so one millisecond is 32 cycles
`default_nettype none
module tb_mpcw_cfg;
    import mpcw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ELO = 4;
    localparam int MS  = ELO * 8;
    logic        clk, rst, wr, ref_clk, ref_run, io1_in, clr, smp, ok;
    logic [31:0] wdata, rdata;
    logic [5:0]  irq;
    logic [1:0]  mode;
    logic        io1_o, io1_oe_n, out2, sctl, wk, wk_oe_n, rail, flag, tmode, fsafe, rsel;
    logic [42:0] q_e[$], q_m[$];
    int          n_fail = 0, n_compared = 0, cyc = 0, t0, seed = 32'h417E;
    wire  logic [42:0] obs = {rdata, mode, io1_o, io1_oe_n, out2, sctl, flag, tmode, fsafe, rsel, rail};
    mpcw_host host_i (.sys_clk_i(clk), .cfg_wr_o(wr), .cfg_wdata_o(wdata));
    mpcw_cfg #(.EDGES_LO(ELO), .EDGES_HI(ELO * 2)) mpcw_cfg_i (.sys_clk_i(clk), .sys_rst_i(rst), .cfg_wr_i(wr),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .ext_clock_in_i(ref_clk), .ctrl_irq_line_i(irq[1:0]),
        .irq_out_low_i(irq[2]), .spi_fault_irq_i(irq[3]), .supply_evt_irq_i(irq[4]), .wake_irq_i(irq[5]),
        .wd_irq_clr_i(clr), .io1_pin_i(io1_in), .io1_pin_o(io1_o), .io1_pin_oe_n_o(io1_oe_n),
        .out2_pin_o(out2), .supply_ctl_pin_o(sctl), .wake_req_pin_o(wk), .wake_req_oe_n_o(wk_oe_n),
        .wake_req_rail_o(rail), .wd_irq_flag_o(flag), .test_mode_o(tmode), .fail_safe_en_o(fsafe),
        .ref_sel_o(rsel), .mode_o(mode));
    // ****************************************************************
    // clocks, timeout and checking
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) ref_clk <= ref_run ? ref_clk ^ (cyc % 4 == 0) : 1'b0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            end_of_test();
        end
    end
    always @(negedge clk) if (smp) cmp(obs, q_e.pop_front(), q_m.pop_front());
    task automatic cmp(input logic [42:0] g, input logic [42:0] e, input logic [42:0] m);
        n_compared++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("ERROR %0t observed %h expected %h mask %h", $time, g, e, m);
        end
    endtask
    task automatic expect_obs(input logic [42:0] e, input logic [42:0] m);
        @(negedge clk);
        q_e.push_back(e);
        q_m.push_back(m);
        smp <= 1'b1;
        @(negedge clk);
        smp <= 1'b0;
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] w;
        logic [1:0]  m;
        {rst, ref_run, io1_in, clr, smp, irq} = 11'h400;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        expect_obs({32'h0800_0468, MODE_STANDBY, 9'h162}, {43'h7FF_FFFF_FFFF});
        m = MODE_STANDBY;
        repeat (8) begin
            w = $random(seed);
            m = (w[7:6] == MODE_RSVD) ? m : w[7:6];
            host_i.write(w);
            expect_obs({(w & 32'h38EB_EF08) | 32'h20 | {24'h0, m, 6'h0}, m, 5'h0, w[21], w[13], w[27], w[19]},
                       {32'hFFFF_FFFF, 2'h3, 9'h00F});
        end
        for (int i = 0; i < 12; i++) begin
            host_i.write({8'h00, 2'(i / 3), 10'h000, 2'(i % 3), 10'h088});
            repeat (3) begin
                @(negedge clk);
                irq = 6'($random(seed));
                expect_obs({34'h0, ~(i % 3 == 0 ? irq[3] : i % 3 == 1 ? irq[1] : irq[4]), 1'b0,
                            (i / 3 == 1) ? ~irq[0] : (i / 3 == 3) ? irq[2] : 1'b1, 6'h20}, {34'h0, 9'h1E0});
            end
        end
        host_i.write(32'h0081_8088);
        expect_obs({32'h0, MODE_NORMAL, 9'h0E0}, {32'h0, 2'h3, 9'h0F0});
        ref_run = 1'b1;
        repeat (1000) @(negedge clk);
        host_i.write(32'h0085_8088);
        t0 = cyc;
        while (flag !== 1'b1 && cyc < t0 + 3000) @(negedge clk);
        ok = (cyc - t0 >= 60 * MS - 40) && (cyc - t0 <= 60 * MS + 40);
        cmp({42'h0, ok}, 43'h1, 43'h1);
        t0 = cyc;
        expect_obs({32'h0004_0000, MODE_STANDBY, 9'h010}, {32'h0004_0000, 2'h3, 9'h030});
        host_i.write(32'h0084_8040);
        expect_obs({32'h0, MODE_STANDBY, 9'h010}, {32'h0004_0000, 2'h3, 9'h030});
        while (sctl !== 1'b1 && cyc < t0 + 20000) @(negedge clk);
        ok = (cyc - t0 >= 300 * MS - 64) && (cyc - t0 <= 300 * MS + 64);
        cmp({42'h0, ok}, 43'h1, 43'h1);
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        expect_obs(43'h0, 43'h010);
        for (int j = 0; j < 4; j++) begin
            host_i.write(32'h0000_8040 | {12'h000, j[0], 10'h000, j[1], 8'h00});
            @(negedge clk) irq = 6'($random(seed));
            repeat (2) @(negedge clk);
            cmp({41'h0, wk, wk_oe_n}, {41'h0, j[1] & ~irq[5], j[0] & j[1] & ~irq[5]}, 43'h3);
        end
        host_i.write(32'h0086_8088);
        t0 = cyc;
        while (flag !== 1'b1 && cyc < t0 + 3000) @(negedge clk);
        expect_obs({32'h0004_0000, MODE_NORMAL, 9'h030}, {32'h0004_0000, 2'h3, 9'h070});
        @(negedge clk) io1_in = 1'b1;
        repeat (2) @(negedge clk);
        expect_obs({32'h0, MODE_NORMAL, 9'h0}, {32'h0004_0000, 2'h3, 9'h0});
        host_i.write(32'h0084_8088);
        t0 = cyc;
        while (rdata[18] !== 1'b1 && cyc < t0 + 3000) @(negedge clk);
        repeat (8200) @(negedge clk);
        expect_obs({32'h0004_0000, MODE_NORMAL, 9'h010}, {32'h0004_0000, 2'h3, 9'h050});
        host_i.write(32'h0080_8080);
        host_i.write(32'h0084_8080);
        expect_obs({32'h0, MODE_NORMAL, 9'h040}, {32'h0004_0000, 2'h3, 9'h040});
        end_of_test();
    end
endmodule
`default_nettype wire
